/* File: dv/mmhl_chk.sv */
// Port checker for the monitor-mode host link
`timescale 1ns/1ps
module mmhl_chk (
  // Clock and resets
  input logic CLOCK,
  input logic RST_N,
  input logic PWR_ON_RST_N,
  // Register bus
  input logic PSEL,
  input logic PENABLE,
  input logic PREADY,
  input logic PSLVERR,
  // Memory port
  input logic MEM_REQ,
  input logic MEM_WR,
  // CPU side
  input logic RUN_PULSE,
  input logic SEC_BYPASSED
);
  // ==========
  // Most checks share the system reset
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Access phase must be answered at once
  a_ready_in_access: assert property (
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY)
    else $error("access phase not answered");
  a_ready_single: assert property ($rose(PREADY) |=> !PREADY)
    else $error("ready held too long");
  a_err_with_ready: assert property (PSLVERR |-> PREADY && PSEL)
    else $error("error without ready");
  a_run_needs_bypass: assert property (RUN_PULSE |-> SEC_BYPASSED)
    else $error("run pulse while locked");
  a_run_single: assert property (RUN_PULSE |=> !RUN_PULSE)
    else $error("run pulse too long");
  a_mem_single: assert property (MEM_REQ |=> !MEM_REQ)
    else $error("memory request too long");
  a_wr_with_req: assert property (MEM_WR |-> MEM_REQ)
    else $error("write strobe without request");
  // Only a power-on reset may take the bypass away
  a_bypass_holds: assert property (@(posedge CLOCK)
    disable iff (!PWR_ON_RST_N) SEC_BYPASSED |=> SEC_BYPASSED)
    else $error("bypass lost without power-on");
  a_por_clears: assert property ($rose(PWR_ON_RST_N) |-> !SEC_BYPASSED)
    else $error("bypass survived power-on");
  // ==========
  // Main scenarios
  c_bypass: cover property ($rose(SEC_BYPASSED));
  c_run: cover property (RUN_PULSE);
  c_err: cover property (PSLVERR);
  c_write: cover property (MEM_REQ && MEM_WR);
endmodule // mmhl_chk

bind mmhl_top mmhl_chk i_mmhl_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .PWR_ON_RST_N(PWR_ON_RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WR(MEM_WR),
  .RUN_PULSE(RUN_PULSE), .SEC_BYPASSED(SEC_BYPASSED));

/* File: dv/mmhl_host.sv */
// Host computer model on the one-wire monitor line
`timescale 1ns/1ps
module mmhl_host #(
  parameter real BIT_NS = 6933.3
) (
  // Line towards the device
  output logic tx_o,
  input logic line_i
);
  real bit_ns = BIT_NS; // Bit time, retuned by the bench per baud
  logic [7:0] rxq [$]; // Frames caught from the device
  // Idle high between frames, like the pull-up
  initial tx_o = 1'h1;
  // ==========
  // Send one 8N1 frame, LSB first
  task send(input logic [7:0] b);
    tx_o = 1'h0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      tx_o = b[i];
      #(bit_ns);
    end
    tx_o = 1'h1;
    #(bit_ns);
  endtask
  // ==========
  // Catch device frames: a low line while our own output is high
  // can only be the device, whose start may overlap our stop bit
  initial begin
    logic [7:0] v;
    forever begin
      wait (line_i === 1'h0 && tx_o === 1'h1);
      #(bit_ns * 1.5);
      for (int i = 0; i < 8; i++) begin
        v[i] = line_i;
        #(bit_ns);
      end
      rxq.push_back(v);
    end
  end
  // Take one caught frame; unknown if none comes in time
  task recv(output logic [7:0] b);
    int i;
    b = 8'hXX;
    i = 0;
    while (rxq.size() == 0 && i < 20000) begin
      #25;
      i++;
    end
    if (rxq.size() != 0) begin
      b = rxq.pop_front();
      // Wait out the stop bit: the device ignores input while sending
      #(bit_ns);
    end
  endtask
endmodule // mmhl_host

/* File: dv/mmhl_tb_top.sv */
// Testbench for the monitor-mode host link
`timescale 1ns/1ps
`include "mmhl_defines.vh"
module mmhl_tb_top;
  // ==========
  // Signals
  logic clock, rst_n, pwr_n, psel, penable, pwrite, strap;
  logic [7:0] paddr, mem_wd, mem_rd, rv;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ser_o, ser_oe, host_tx, wire_lvl, er;
  logic mem_req, mem_wr, run_p, byp_o;
  logic [15:0] mem_addr, cpu_sp, rnd;
  logic [7:0] mem [0:65535];
  logic [7:0] mdl [int];
  int miscompares, checked, runs, byp;
  // One wire: device drives only with its enable up
  assign wire_lvl = ser_oe ? ser_o : host_tx;
  always #12.5 clock = ~clock;
  mmhl_top i_mmhl_top (.CLOCK(clock), .RST_N(rst_n), .PWR_ON_RST_N(pwr_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BAUD_SELECT_PIN(strap), .MONITOR_SERIAL_PIN_I(wire_lvl),
    .MONITOR_SERIAL_PIN_O(ser_o), .MONITOR_SERIAL_PIN_OE(ser_oe),
    .MEM_REQ(mem_req), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wd), .MEM_RDATA(mem_rd), .CPU_SP(cpu_sp),
    .RUN_PULSE(run_p), .SEC_BYPASSED(byp_o));
  // Bit time: 16 x 260 clocks at the 9600 base, divided by N = 15
  mmhl_host #(.BIT_NS(25.0 * 4160.0 / 15.0)) i_mmhl_host (
    .tx_o(host_tx),
    .line_i(wire_lvl)
  );
  // ==========
  // Memory answers next cycle; idle data toggles, never holds
  always @(posedge clock) begin
    if (mem_req) begin
      mem_rd <= mem[mem_addr];
      if (mem_wr) mem[mem_addr] <= mem_wd;
    end else mem_rd <= ~mem_rd;
    if (run_p === 1'h1) runs++;
  end
  // ==========
  // Model
  function logic [7:0] f(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [7:0] ex(input logic [15:0] a);
    if (byp == 0 && a >= `MMHL_FLASH_LO) return `MMHL_REFUSE;
    return mdl.exists(a) ? mdl[a] : f(a);
  endfunction
  // ==========
  // Tasks
  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // APB master: hold request until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
    if (k >= 20) begin
      miscompares++;
      end_sim;
    end
  endtask
  // Reset, then fastest baud: PLL on with N = 15
  task rst(input logic por);
    @(posedge clock);
    rst_n <= 1'h0;
    pwr_n <= ~por;
    repeat (12) @(posedge clock);
    {rst_n, pwr_n} <= 2'h3;
    if (por) byp = 0;
    @(posedge clock);
    apb(1'h0, 8'h78, 32'h0);
    chk("pll_reset", 32'h60, rd);
    apb(1'h1, 8'h78, 32'hF0);
    apb(1'h1, 8'h7C, 32'h1);
  endtask
  task sb(input logic [7:0] b);
    i_mmhl_host.send(b);
  endtask
  task adr(input logic [7:0] c, input logic [15:0] a);
    sb(c);
    sb(a[15:8]);
    sb(a[7:0]);
  endtask
  task rb(input string n, input logic [7:0] e);
    i_mmhl_host.recv(rv);
    chk(n, {24'h0, e}, {24'h0, rv});
    // No frame within the limit: already counted, stop here
    if ($isunknown(rv)) end_sim;
  endtask
  // Security entry; bad flips one bit of the fourth byte
  task sec(input logic [7:0] bad);
    for (int i = 0; i < 8; i++)
      sb(f(16'hFFF6 + 16'(i)) ^ (i == 3 ? bad : 8'h00));
    byp = (bad == 8'h00);
    chk("bypass", 32'(byp), {31'h0, byp_o});
  endtask
  // ==========
  // Main sequence
  initial begin
    {clock, psel, penable, pwrite, strap, rst_n, pwr_n} = 7'h0;
    {paddr, pwdata, cpu_sp, mem_rd} = 64'h0;
    {miscompares, checked, runs, byp} = 128'h0;
    rnd = 16'h7DDF;
    for (int a = 0; a < 65536; a++) mem[a] = f(16'(a));
    rst(1'h1);
    apb(1'h0, 8'h84, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'h0, 8'h80, 32'h0);
    chk("entry_wait", 32'h8, rd & 32'hC);
    sec(8'h10);
    rnd = lfsr(rnd);
    adr(`MMHL_CMD_WRITE, 16'h0100);
    sb(rnd[7:0]);
    mdl[16'h0100] = rnd[7:0];
    adr(`MMHL_CMD_READ, 16'h8001);
    rb("locked_read", ex(16'h8001));
    sb(`MMHL_CMD_RUN);
    chk("locked_run", 32'h0, runs);
    rst(1'h1);
    sec(8'h00);
    adr(`MMHL_CMD_READ, 16'h8001);
    rb("flash_read", ex(16'h8001));
    sb(`MMHL_CMD_INDEXED_READ_CMD);
    rb("index_read", ex(16'h8002));
    rnd = lfsr(rnd);
    sb(`MMHL_CMD_INDEXED_WRITE_CMD);
    sb(rnd[15:8]);
    mdl[16'h8003] = rnd[15:8];
    rnd = lfsr(rnd);
    @(posedge clock);
    cpu_sp <= rnd;
    sb(`MMHL_CMD_SPREAD);
    rb("sp_hi", rnd[15:8]);
    rb("sp_lo", rnd[7:0]);
    sb(`MMHL_CMD_RUN);
    chk("run", 32'h1, runs);
    @(posedge clock);
    strap <= 1'h1;
    rst(1'h0);
    apb(1'h0, 8'h80, 32'h0);
    chk("warm_status", 32'h5, rd & 32'hD);
    // Strap high, slower crystal: 16 x 610 clocks per bit, over N = 15
    apb(1'h1, 8'h7C, 32'h3);
    i_mmhl_host.bit_ns = 25.0 * 9760.0 / 15.0;
    rnd = lfsr(rnd);
    @(posedge clock);
    cpu_sp <= rnd;
    sb(`MMHL_CMD_SPREAD);
    rb("alt_sp_hi", rnd[15:8]);
    rb("alt_sp_lo", rnd[7:0]);
    chk("ram_write", {24'h0, mdl[16'h0100]}, {24'h0, mem[16'h0100]});
    chk("index_write", {24'h0, mdl[16'h8003]}, {24'h0, mem[16'h8003]});
    end_sim;
  end
endmodule // mmhl_tb_top

/* File: hw/mmhl_defines.vh */
// Constants for the monitor-mode host link
// Function
// - Six host commands are accepted
// - Indexed commands step through memory sequentially
// - Select pin high: 4800 baud base rate
// - Select pin low: 9600 baud base rate
// - PLL clocking scales baud by multiplier N
// - Multiplier zero behaves exactly as one
// - Multiplier field resets to six
// - Eight host bytes compared with FFF6-FFFD
// - After power-on, wait for security bytes
// - Match grants flash read and execution
// - Bypass holds until next power-on reset
// - Other resets keep bypass, no re-entry
`ifndef MMHL_DEFINES_VH
`define MMHL_DEFINES_VH

// ======================================================
// Register map (index, byte address is index times four)
`define MMHL_IDX_PLLCFG 6'h1E
`define MMHL_IDX_CTRL 6'h1F
`define MMHL_IDX_STAT 6'h20
`define MMHL_MUL_HI 7
`define MMHL_MUL_LO 4
`define MMHL_MUL_RST 4'h6
`define MMHL_CTRL_PLLSEL 0
`define MMHL_CTRL_XTALALT 1

// ======================================================
// Timing
`define MMHL_CLK_HZ 40000000
`define MMHL_BAUD_HI 4800
`define MMHL_BAUD_LO 9600
`define MMHL_BAUD_ALT_HI 4096
`define MMHL_BAUD_ALT_LO 8192
`define MMHL_OVS 16
`define MMHL_DIV(b) (`MMHL_CLK_HZ / (`MMHL_OVS * (b)))

// ======================================================
// Monitor protocol
`define MMHL_CMD_READ 8'h01
`define MMHL_CMD_WRITE 8'h02
`define MMHL_CMD_INDEXED_READ_CMD 8'h03
`define MMHL_CMD_INDEXED_WRITE_CMD 8'h04
`define MMHL_CMD_SPREAD 8'h05
`define MMHL_CMD_RUN 8'h06
`define MMHL_SEC_BASE 16'hFFF6
`define MMHL_SEC_LEN 4'h8
`define MMHL_FLASH_LO 16'h8000
`define MMHL_REFUSE 8'h00

`endif

/* File: hw/mmhl_top.v */
// Monitor-mode host link: command engine, security, baud, APB regs
`timescale 1ns/1ps
`include "mmhl_defines.vh"
module mmhl_top (
  // Clock and resets
  input wire CLOCK,
  input wire RST_N,
  input wire PWR_ON_RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Pins
  input wire BAUD_SELECT_PIN,
  input wire MONITOR_SERIAL_PIN_I,
  output wire MONITOR_SERIAL_PIN_O,
  output wire MONITOR_SERIAL_PIN_OE,
  // System memory port, read data one cycle after request
  output reg MEM_REQ,
  output reg MEM_WR,
  output reg [15:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  // CPU side
  input wire [15:0] CPU_SP,
  output reg RUN_PULSE,
  output reg SEC_BYPASSED
);
  // ======================================================
  // States
  localparam S_IDLE = 4'h0;
  localparam S_AHI = 4'h1;
  localparam S_ALO = 4'h2;
  localparam S_DAT = 4'h3;
  localparam S_MEM = 4'h4;
  localparam S_MRES = 4'h5;
  localparam S_TX = 4'h6;
  localparam S_SECR = 4'h7;
  localparam S_SECC = 4'h8;
  localparam S_MWT = 4'h9;

  reg [3:0] st_ff; // Command state
  reg [7:0] cmd_ff; // Current command
  reg [15:0] ptr_ff; // Address pointer
  reg [7:0] txd_ff; // Byte to send
  reg tx_go_ff; // Send request pulse
  reg more_ff; // Second byte pending
  reg [7:0] more_d_ff; // Second byte value
  reg need_sec_ff; // Security entry still pending
  reg [3:0] sec_cnt_ff; // Security bytes seen
  reg sec_bad_ff; // Some byte mismatched
  reg [7:0] sec_byte_ff; // Last received security byte
  reg [3:0] mul_ff; // Multiplier select field
  reg [3:0] pll_low_ff; // Low field of config register
  reg pll_sel_ff; // PLL drives clock generator output
  reg xtal_alt_ff; // Alternate crystal installed
  reg baud_lat_ff; // Select pin caught at reset
  reg [1:0] bsel_sync_ff; // Select pin synchroniser
  reg [1:0] rx_sync_ff; // Serial pin synchroniser
  reg [11:0] acc_ff; // Baud phase accumulator
  reg tick_ff; // Oversample tick
  wire rx_valid;
  wire [7:0] rx_data;
  wire tx_busy;

  // ======================================================
  // Helpers
  function is_flash;
    input [15:0] a;
    begin
      is_flash = (a >= `MMHL_FLASH_LO);
    end
  endfunction

  // Effective N: zero acts as one, no PLL means one
  function [3:0] eff_n;
    input [3:0] m;
    input pll;
    begin
      if (!pll || m == 4'h0) begin
        eff_n = 4'h1;
      end else begin
        eff_n = m;
      end
    end
  endfunction

  // ======================================================
  // Pin synchronisers, strap caught during reset
  always @(posedge CLOCK) begin
    bsel_sync_ff <= {bsel_sync_ff[0], BAUD_SELECT_PIN};
    rx_sync_ff <= {rx_sync_ff[0], MONITOR_SERIAL_PIN_I};
    if (!RST_N) begin
      baud_lat_ff <= bsel_sync_ff[1];
    end
  end

  // ======================================================
  // Baud: tick rate = 16 * base * N via phase accumulator
  // Dividers per base rate; all fit 12 bits, so the part-select is safe
  localparam [31:0] DIV_HI = `MMHL_DIV(`MMHL_BAUD_HI);
  localparam [31:0] DIV_LO = `MMHL_DIV(`MMHL_BAUD_LO);
  localparam [31:0] DIV_AHI = `MMHL_DIV(`MMHL_BAUD_ALT_HI);
  localparam [31:0] DIV_ALO = `MMHL_DIV(`MMHL_BAUD_ALT_LO);
  wire [11:0] div = xtal_alt_ff ?
    (baud_lat_ff ? DIV_AHI[11:0] : DIV_ALO[11:0]) :
    (baud_lat_ff ? DIV_HI[11:0] : DIV_LO[11:0]);
  wire [11:0] acc_sum = acc_ff + {8'h00, eff_n(mul_ff, pll_sel_ff)};

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      acc_ff <= 12'h000;
      tick_ff <= 1'b0;
    end else if (acc_sum >= div) begin
      acc_ff <= acc_sum - div;
      tick_ff <= 1'b1;
    end else begin
      acc_ff <= acc_sum;
      tick_ff <= 1'b0;
    end
  end

  mmhl_uart u_uart (
    .clk(CLOCK),
    .rst_n(RST_N),
    .tick(tick_ff),
    .rx_i(rx_sync_ff[1]),
    .tx_o(MONITOR_SERIAL_PIN_O),
    .tx_oe(MONITOR_SERIAL_PIN_OE),
    .tx_go(tx_go_ff),
    .tx_data(txd_ff),
    .tx_busy(tx_busy),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  // ======================================================
  // Security state: cleared by power-on reset only
  always @(posedge CLOCK) begin
    if (!PWR_ON_RST_N) begin
      SEC_BYPASSED <= 1'b0;
      need_sec_ff <= 1'b1;
    end else if (st_ff == S_SECC && sec_cnt_ff == `MMHL_SEC_LEN) begin
      // Other resets never reach here again
      need_sec_ff <= 1'b0;
      SEC_BYPASSED <= ~sec_bad_ff;
    end
  end

  // ======================================================
  // Command engine
  always @(posedge CLOCK) begin
    tx_go_ff <= 1'b0;
    MEM_REQ <= 1'b0;
    MEM_WR <= 1'b0;
    RUN_PULSE <= 1'b0;
    if (!RST_N) begin
      st_ff <= S_IDLE;
      cmd_ff <= 8'h00;
      ptr_ff <= 16'h0000;
      txd_ff <= 8'h00;
      more_ff <= 1'b0;
      more_d_ff <= 8'h00;
      sec_cnt_ff <= 4'h0;
      sec_bad_ff <= 1'b0;
      sec_byte_ff <= 8'h00;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (rx_valid && need_sec_ff && PWR_ON_RST_N) begin
            // Fetch stored byte to compare
            sec_byte_ff <= rx_data;
            MEM_REQ <= 1'b1;
            MEM_ADDR <= `MMHL_SEC_BASE + {12'h000, sec_cnt_ff};
            st_ff <= S_SECR;
          end else if (rx_valid) begin
            cmd_ff <= rx_data;
            case (rx_data)
              `MMHL_CMD_READ, `MMHL_CMD_WRITE: st_ff <= S_AHI;
              `MMHL_CMD_INDEXED_READ_CMD: st_ff <= S_MEM;
              `MMHL_CMD_INDEXED_WRITE_CMD: st_ff <= S_DAT;
              `MMHL_CMD_SPREAD: begin
                txd_ff <= CPU_SP[15:8];
                more_d_ff <= CPU_SP[7:0];
                more_ff <= 1'b1;
                tx_go_ff <= 1'b1;
                st_ff <= S_TX;
              end
              `MMHL_CMD_RUN: begin
                // Code would run from flash; only if bypassed
                RUN_PULSE <= SEC_BYPASSED;
              end
              default: st_ff <= S_IDLE; // Unknown byte dropped
            endcase
          end
        end
        S_SECR: begin
          st_ff <= S_SECC; // Read data arrives next cycle, in S_SECC
        end
        S_SECC: begin
          if (sec_cnt_ff == `MMHL_SEC_LEN) begin
            st_ff <= S_IDLE; // Entry done
          end else begin
            if (MEM_RDATA != sec_byte_ff) begin
              sec_bad_ff <= 1'b1;
            end
            sec_cnt_ff <= sec_cnt_ff + 4'h1;
            if (sec_cnt_ff == `MMHL_SEC_LEN - 4'h1) begin
              st_ff <= S_SECC; // One more pass to commit
            end else begin
              st_ff <= S_IDLE;
            end
          end
        end
        S_AHI: begin
          if (rx_valid) begin
            ptr_ff[15:8] <= rx_data;
            st_ff <= S_ALO;
          end
        end
        S_ALO: begin
          if (rx_valid) begin
            ptr_ff[7:0] <= rx_data;
            st_ff <= (cmd_ff == `MMHL_CMD_WRITE) ? S_DAT : S_MEM;
          end
        end
        S_DAT: begin
          if (rx_valid) begin
            MEM_REQ <= 1'b1;
            MEM_WR <= 1'b1;
            MEM_ADDR <= ptr_ff;
            MEM_WDATA <= rx_data;
            ptr_ff <= ptr_ff + 16'h0001;
            st_ff <= S_IDLE;
          end
        end
        S_MEM: begin
          if (is_flash(ptr_ff) && !SEC_BYPASSED) begin
            txd_ff <= `MMHL_REFUSE;
            tx_go_ff <= 1'b1;
            st_ff <= S_TX;
          end else begin
            MEM_REQ <= 1'b1;
            MEM_ADDR <= ptr_ff;
            st_ff <= S_MWT;
          end
          ptr_ff <= ptr_ff + 16'h0001;
        end
        S_MWT: begin
          st_ff <= S_MRES; // Memory answers the cycle after the request
        end
        S_MRES: begin
          txd_ff <= MEM_RDATA;
          tx_go_ff <= 1'b1;
          st_ff <= S_TX;
        end
        S_TX: begin
          // Wait until the transmitter took and sent the byte
          if (!tx_go_ff && !tx_busy) begin
            if (more_ff) begin
              more_ff <= 1'b0;
              txd_ff <= more_d_ff;
              tx_go_ff <= 1'b1;
            end else begin
              st_ff <= S_IDLE;
            end
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // ======================================================
  // APB slave: no wait state, answer registered in setup phase
  wire [5:0] idx = PADDR[7:2];
  wire hit = (idx == `MMHL_IDX_PLLCFG) || (idx == `MMHL_IDX_CTRL) ||
    (idx == `MMHL_IDX_STAT);

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      mul_ff <= `MMHL_MUL_RST;
      pll_low_ff <= 4'h0;
      pll_sel_ff <= 1'b0;
      xtal_alt_ff <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      // Setup phase: prepare answer for access phase
      PREADY <= 1'b1;
      PSLVERR <= ~hit;
      PRDATA <= 32'h00000000;
      if (!PWRITE) begin
        case (idx)
          `MMHL_IDX_PLLCFG: PRDATA[7:0] <= {mul_ff, pll_low_ff};
          `MMHL_IDX_CTRL: PRDATA[1:0] <= {xtal_alt_ff, pll_sel_ff};
          `MMHL_IDX_STAT: PRDATA[3:0] <= {need_sec_ff, baud_lat_ff,
                                          sec_bad_ff, SEC_BYPASSED};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end else if (PSEL && PENABLE && PREADY) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      if (PWRITE && idx == `MMHL_IDX_PLLCFG) begin
        mul_ff <= PWDATA[`MMHL_MUL_HI:`MMHL_MUL_LO];
        pll_low_ff <= PWDATA[3:0];
      end
      if (PWRITE && idx == `MMHL_IDX_CTRL) begin
        pll_sel_ff <= PWDATA[`MMHL_CTRL_PLLSEL];
        xtal_alt_ff <= PWDATA[`MMHL_CTRL_XTALALT];
      end
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end
endmodule // mmhl_top

/* File: hw/mmhl_uart.v */
// Oversampled one-wire serial transceiver, 8N1
`timescale 1ns/1ps
module mmhl_uart (
  // Clock, reset, oversample tick
  input wire clk,
  input wire rst_n,
  input wire tick,
  // Line, already synchronised
  input wire rx_i,
  output reg tx_o,
  output reg tx_oe,
  // Byte side
  input wire tx_go,
  input wire [7:0] tx_data,
  output reg tx_busy,
  output reg rx_valid,
  output reg [7:0] rx_data
);
  reg [3:0] rx_sub; // Ticks inside a bit
  reg [3:0] rx_bit; // Bit index, 0 start .. 9 stop
  reg rx_act; // Frame in progress
  reg [3:0] tx_sub;
  reg [3:0] tx_bit;
  reg [9:0] tx_sh; // Stop, data, start

  // ======================================================
  // Receiver: ignored while we drive the shared wire
  always @(posedge clk) begin
    rx_valid <= 1'b0;
    if (!rst_n) begin
      rx_act <= 1'b0;
      rx_sub <= 4'h0;
      rx_bit <= 4'h0;
      rx_data <= 8'h00;
    end else if (tick) begin
      if (!rx_act) begin
        // Start edge seen; first sample lands mid-bit
        if (!rx_i && !tx_busy) begin
          rx_act <= 1'b1;
          rx_sub <= 4'h8;
          rx_bit <= 4'h0;
        end
      end else if (rx_sub == 4'hF) begin
        rx_sub <= 4'h0;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_i) begin
          rx_act <= 1'b0; // Glitch, not a start bit
        end else if (rx_bit == 4'h9) begin
          rx_act <= 1'b0;
          rx_valid <= rx_i; // Framing error drops byte
        end else if (rx_bit != 4'h0) begin
          rx_data <= {rx_i, rx_data[7:1]};
        end
      end else begin
        rx_sub <= rx_sub + 4'h1;
      end
    end
  end

  // ======================================================
  // Transmitter, LSB first
  always @(posedge clk) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_o <= 1'b1;
      tx_oe <= 1'b0;
      tx_sh <= 10'h3FF;
      tx_sub <= 4'h0;
      tx_bit <= 4'h0;
    end else if (!tx_busy) begin
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh <= {1'b1, tx_data, 1'b0};
        tx_sub <= 4'h0;
        tx_bit <= 4'h0;
      end
    end else if (tick) begin
      tx_oe <= 1'b1;
      tx_o <= tx_sh[0];
      if (tx_sub == 4'hF) begin
        tx_sub <= 4'h0;
        tx_sh <= {1'b1, tx_sh[9:1]};
        if (tx_bit == 4'h9) begin
          tx_busy <= 1'b0;
          tx_oe <= 1'b0; // Release wire after stop bit
          tx_o <= 1'b1;
        end
        tx_bit <= tx_bit + 4'h1;
      end else begin
        tx_sub <= tx_sub + 4'h1;
      end
    end
  end
endmodule // mmhl_uart
